// file: timer16_cc_defs.vh
`ifndef TIMER16_CC_DEFS_VH
`define TIMER16_CC_DEFS_VH

// Register indices on the plain register port.
`define REG_CTRL1 4'h0
`define REG_CTRL2 4'h1
`define REG_STATUS 4'h2
`define REG_CAP1_HI 4'h3
`define REG_CAP1_LO 4'h4
`define REG_CAP2_HI 4'h5
`define REG_CAP2_LO 4'h6
`define REG_CMP1_HI 4'h7
`define REG_CMP1_LO 4'h8
`define REG_CMP2_HI 4'h9
`define REG_CMP2_LO 4'hA
`define REG_CNT_HI 4'hB
`define REG_CNT_LO 4'hC

// Control register one fields.
`define C1_CAP_IE 7
`define C1_CMP_IE 6
`define C1_OVF_IE 5
`define C1_FORCE2 4
`define C1_FORCE1 3
`define C1_LEVEL2 2
`define C1_EDGE1 1
`define C1_LEVEL1 0
`define CTRL1_RST 8'h00

// Control register two fields.
`define C2_OE1 7
`define C2_OE2 6
`define C2_ONE_PULSE 5
`define C2_PWM 4
`define C2_CLKSEL_HI 3
`define C2_CLKSEL_LO 2
`define C2_EDGE2 1
`define CTRL2_RST 8'h00

// Status register fields.
`define STAT_CAPF1 7
`define STAT_CMPF1 6
`define STAT_OVF 5
`define STAT_CAPF2 4
`define STAT_CMPF2 3

`endif

// file: timer16_capture_compare.v
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cc_defs.vh"

module timer16_capture_compare (
    input wire clk,
    input wire sys_rst,
    input wire clk_en,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire cpu_irq_mask,
    input wire capture_pin_ch1,
    input wire capture_pin_ch2,
    output reg compare_pin_ch1,
    output reg compare_pin_ch2,
    output wire compare_output_enable_ch1,
    output wire compare_output_enable_ch2,
    output wire timer_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Register state.
    reg [7:0] ctrl1_ff;
    reg [7:0] ctrl2_ff;
    reg [15:0] count_ff;
    reg [2:0] presc_ff;
    reg [15:0] cap1_ff;
    reg [15:0] cap2_ff;
    reg [15:0] cmp1_ff;
    reg [15:0] cmp2_ff;
    reg cmp1_hold_ff;
    reg cmp2_hold_ff;
    reg cap1_block_ff;
    reg cap2_block_ff;
    reg capf1_ff;
    reg capf2_ff;
    reg cmpf1_ff;
    reg cmpf2_ff;
    reg ovf_ff;
    reg arm_capf1_ff;
    reg arm_capf2_ff;
    reg arm_cmpf1_ff;
    reg arm_cmpf2_ff;
    reg arm_ovf_ff;
    reg [2:0] sync1_ff;
    reg [2:0] sync2_ff;

    ////////////////////////////////////////////////////////////////////////
    // Decoded strobes and modes.
    wire pulse_mode = ctrl2_ff[`C2_ONE_PULSE] | ctrl2_ff[`C2_PWM];
    wire wr_ctrl1 = reg_wr & (reg_addr == `REG_CTRL1);
    wire wr_ctrl2 = reg_wr & (reg_addr == `REG_CTRL2);
    wire rd_status = reg_rd & (reg_addr == `REG_STATUS);
    wire rd_cap1_hi = reg_rd & (reg_addr == `REG_CAP1_HI);
    wire rd_cap2_hi = reg_rd & (reg_addr == `REG_CAP2_HI);
    wire acc_cap1_lo = (reg_rd | reg_wr) & (reg_addr == `REG_CAP1_LO);
    wire acc_cap2_lo = (reg_rd | reg_wr) & (reg_addr == `REG_CAP2_LO);
    wire rd_cap1_lo = reg_rd & (reg_addr == `REG_CAP1_LO);
    wire rd_cap2_lo = reg_rd & (reg_addr == `REG_CAP2_LO);
    wire rd_cnt_lo = reg_rd & (reg_addr == `REG_CNT_LO);
    wire wr_cmp1_hi = reg_wr & (reg_addr == `REG_CMP1_HI);
    wire wr_cmp1_lo = reg_wr & (reg_addr == `REG_CMP1_LO);
    wire wr_cmp2_hi = reg_wr & (reg_addr == `REG_CMP2_HI);
    wire wr_cmp2_lo = reg_wr & (reg_addr == `REG_CMP2_LO);

    assign compare_output_enable_ch1 = ctrl2_ff[`C2_OE1];
    assign compare_output_enable_ch2 = ctrl2_ff[`C2_OE2];

    ////////////////////////////////////////////////////////////////////////
    // Prescaler tick: divide by 1, 2, 4 or 8 as chosen by the clock select.
    wire [1:0] clk_sel = ctrl2_ff[`C2_CLKSEL_HI:`C2_CLKSEL_LO];
    reg tick;
    always @*
    begin
        case (clk_sel)
            2'h0: tick = 1'b1;
            2'h1: tick = (presc_ff[0] == 1'b1);
            2'h2: tick = (presc_ff[1:0] == 2'h3);
            default: tick = (presc_ff == 3'h7);
        endcase
    end

    wire wrap = tick & (count_ff == 16'hFFFF);

    ////////////////////////////////////////////////////////////////////////
    // Edge detection on synchronised capture pins; bit 0 is the first stage.
    wire s1 = sync1_ff[1];
    wire s1_old = sync1_ff[2];
    wire s2 = sync2_ff[1];
    wire s2_old = sync2_ff[2];
    wire edge1 = ctrl1_ff[`C1_EDGE1] ? (s1 & ~s1_old) : (~s1 & s1_old);
    wire edge2 = ctrl2_ff[`C2_EDGE2] ? (s2 & ~s2_old) : (~s2 & s2_old);
    wire cap1_ev = edge1 & ~cap1_block_ff & ~pulse_mode;
    wire cap2_ev = edge2 & ~cap2_block_ff;

    ////////////////////////////////////////////////////////////////////////
    // Compare matches are live while the counter equals the value and no high write is holding it.
    wire match1 = (count_ff == cmp1_ff) & ~cmp1_hold_ff;
    wire match2 = (count_ff == cmp2_ff) & ~cmp2_hold_ff;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request: each flag gated by its enable and the CPU mask.
    assign timer_irq = ~cpu_irq_mask & (
        (ctrl1_ff[`C1_CAP_IE] & (capf1_ff | capf2_ff)) |
        (ctrl1_ff[`C1_CMP_IE] & (cmpf1_ff | cmpf2_ff)) |
        (ctrl1_ff[`C1_OVF_IE] & ovf_ff));

    ////////////////////////////////////////////////////////////////////////
    // Control registers, counter and prescaler.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl1_ff <= `CTRL1_RST;
            ctrl2_ff <= `CTRL2_RST;
            count_ff <= 16'h0000;
            presc_ff <= 3'h0;
        end
        else if (clk_en)
        begin
            if (wr_ctrl1)
            begin
                ctrl1_ff <= reg_wdata;
            end
            if (wr_ctrl2)
            begin
                ctrl2_ff <= reg_wdata;
            end
            presc_ff <= presc_ff + 3'h1;
            if (tick)
            begin
                count_ff <= count_ff + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: stage 0 is read only by stage 1.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end
        else if (clk_en)
        begin
            sync1_ff <= {sync1_ff[1:0], capture_pin_ch1};
            sync2_ff <= {sync2_ff[1:0], capture_pin_ch2};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture registers and their high-byte read blocks.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            cap1_ff <= 16'h0000;
            cap2_ff <= 16'h0000;
            cap1_block_ff <= 1'b0;
            cap2_block_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cap1_ev)
            begin
                cap1_ff <= count_ff;
            end
            if (cap2_ev)
            begin
                cap2_ff <= count_ff;
            end
            if (rd_cap1_hi)
            begin
                cap1_block_ff <= 1'b1;
            end
            else if (rd_cap1_lo)
            begin
                cap1_block_ff <= 1'b0;
            end
            if (rd_cap2_hi)
            begin
                cap2_block_ff <= 1'b1;
            end
            else if (rd_cap2_lo)
            begin
                cap2_block_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare registers: a high write holds the compare until the low write.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            cmp1_ff <= 16'hFFFF;
            cmp2_ff <= 16'hFFFF;
            cmp1_hold_ff <= 1'b0;
            cmp2_hold_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_cmp1_hi)
            begin
                cmp1_ff[15:8] <= reg_wdata;
                cmp1_hold_ff <= 1'b1;
            end
            if (wr_cmp1_lo)
            begin
                cmp1_ff[7:0] <= reg_wdata;
                cmp1_hold_ff <= 1'b0;
            end
            if (wr_cmp2_hi)
            begin
                cmp2_ff[15:8] <= reg_wdata;
                cmp2_hold_ff <= 1'b1;
            end
            if (wr_cmp2_lo)
            begin
                cmp2_ff[7:0] <= reg_wdata;
                cmp2_hold_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags. A status read arms the clear; the follow-up access
    // clears. A new set in the same cycle wins over the clear.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            capf1_ff <= 1'b0;
            capf2_ff <= 1'b0;
            cmpf1_ff <= 1'b0;
            cmpf2_ff <= 1'b0;
            ovf_ff <= 1'b0;
            arm_capf1_ff <= 1'b0;
            arm_capf2_ff <= 1'b0;
            arm_cmpf1_ff <= 1'b0;
            arm_cmpf2_ff <= 1'b0;
            arm_ovf_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rd_status)
            begin
                arm_capf1_ff <= capf1_ff;
                arm_capf2_ff <= capf2_ff;
                arm_cmpf1_ff <= cmpf1_ff;
                arm_cmpf2_ff <= cmpf2_ff;
                arm_ovf_ff <= ovf_ff;
            end
            if (cap1_ev)
            begin
                capf1_ff <= 1'b1;
            end
            else if (acc_cap1_lo & arm_capf1_ff)
            begin
                capf1_ff <= 1'b0;
                arm_capf1_ff <= 1'b0;
            end
            if (cap2_ev)
            begin
                capf2_ff <= 1'b1;
            end
            else if (acc_cap2_lo & arm_capf2_ff)
            begin
                capf2_ff <= 1'b0;
                arm_capf2_ff <= 1'b0;
            end
            if (match1)
            begin
                cmpf1_ff <= 1'b1;
            end
            else if (wr_cmp1_lo & arm_cmpf1_ff)
            begin
                cmpf1_ff <= 1'b0;
                arm_cmpf1_ff <= 1'b0;
            end
            if (match2)
            begin
                cmpf2_ff <= 1'b1;
            end
            else if (wr_cmp2_lo & arm_cmpf2_ff)
            begin
                cmpf2_ff <= 1'b0;
                arm_cmpf2_ff <= 1'b0;
            end
            if (wrap)
            begin
                ovf_ff <= 1'b1;
            end
            else if (rd_cnt_lo & arm_ovf_ff)
            begin
                ovf_ff <= 1'b0;
                arm_ovf_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare pins: in plain mode match or force copies the level when output enabled; pulse mode drives only pin one, on match, with level two.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            compare_pin_ch1 <= 1'b0;
            compare_pin_ch2 <= 1'b0;
        end
        else if (clk_en)
        begin
            if (pulse_mode)
            begin
                if (match1 & ctrl2_ff[`C2_OE1])
                begin
                    compare_pin_ch1 <= ctrl1_ff[`C1_LEVEL2];
                end
            end
            else
            begin
                if (ctrl2_ff[`C2_OE1] & (match1 | ctrl1_ff[`C1_FORCE1]))
                begin
                    compare_pin_ch1 <= ctrl1_ff[`C1_LEVEL1];
                end
                if (ctrl2_ff[`C2_OE2] & (match2 | ctrl1_ff[`C1_FORCE2]))
                begin
                    compare_pin_ch2 <= ctrl1_ff[`C1_LEVEL2];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the read strobe; unmapped reads give zero.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (clk_en)
        begin
            reg_rdata <= 8'h00;
            if (reg_rd)
            begin
                case (reg_addr)
                    `REG_CTRL1: reg_rdata <= ctrl1_ff;
                    `REG_CTRL2: reg_rdata <= ctrl2_ff;
                    `REG_STATUS: reg_rdata <= {capf1_ff, cmpf1_ff, ovf_ff, capf2_ff,
                        cmpf2_ff, 3'h0};
                    `REG_CAP1_HI: reg_rdata <= cap1_ff[15:8];
                    `REG_CAP1_LO: reg_rdata <= cap1_ff[7:0];
                    `REG_CAP2_HI: reg_rdata <= cap2_ff[15:8];
                    `REG_CAP2_LO: reg_rdata <= cap2_ff[7:0];
                    `REG_CMP1_HI: reg_rdata <= cmp1_ff[15:8];
                    `REG_CMP1_LO: reg_rdata <= cmp1_ff[7:0];
                    `REG_CMP2_HI: reg_rdata <= cmp2_ff[15:8];
                    `REG_CMP2_LO: reg_rdata <= cmp2_ff[7:0];
                    `REG_CNT_HI: reg_rdata <= count_ff[15:8];
                    `REG_CNT_LO: reg_rdata <= count_ff[7:0];
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule // timer16_capture_compare
`default_nettype wire

// file: capture_pin_driver.sv
`timescale 1ns/1ps
`default_nettype none
module capture_pin_driver (
    input wire logic clk,
    input wire logic want_ch1,
    input wire logic want_ch2,
    output var logic capture_pin_ch1,
    output var logic capture_pin_ch2
);
    // The external source moves its pins just after an edge, never on the sampling instant.
    always @(posedge clk)
    begin
        capture_pin_ch1 <= want_ch1;
        capture_pin_ch2 <= want_ch2;
    end
endmodule // capture_pin_driver
`default_nettype wire

// file: timer16_cc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cc_defs.vh"
module timer16_cc_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic cpu_irq_mask,
    input wire logic capture_pin_ch1,
    input wire logic capture_pin_ch2,
    input wire logic compare_pin_ch1,
    input wire logic compare_pin_ch2,
    input wire logic compare_output_enable_ch1,
    input wire logic compare_output_enable_ch2,
    input wire logic timer_irq
);
    logic [7:0] ctrl1_ff;
    logic [7:0] ctrl2_ff;
    // Shadows of both control registers, rebuilt from accepted writes.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl1_ff <= 8'h00;
            ctrl2_ff <= 8'h00;
        end
        else if (reg_wr && clk_en && reg_addr == `REG_CTRL1)
            ctrl1_ff <= reg_wdata;
        else if (reg_wr && clk_en && reg_addr == `REG_CTRL2)
            ctrl2_ff <= reg_wdata;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Building blocks for the multi-step relations.
    sequence s_ctrl1_wr;
        clk_en && reg_wr && reg_addr == `REG_CTRL1;
    endsequence
    sequence s_ctrl1_rd;
        clk_en && reg_rd && reg_addr == `REG_CTRL1;
    endsequence
    sequence s_plain_mode;
        ctrl2_ff[`C2_ONE_PULSE] == 1'b0 && ctrl2_ff[`C2_PWM] == 1'b0;
    endsequence
    a_reset_quiet: assert property ($fell(sys_rst) |->
        !timer_irq && !compare_pin_ch1 && !compare_pin_ch2 && reg_rdata == 8'h00)
        else $error("outputs not quiet after reset");
    a_ctrl1_read_back: assert property (s_ctrl1_wr ##1 !reg_wr ##1 s_ctrl1_rd |=>
        reg_rdata == $past(reg_wdata, 3))
        else $error("control one read back differs");
    a_irq_cpu_masked: assert property (cpu_irq_mask |-> !timer_irq)
        else $error("interrupt raised while masked");
    a_irq_needs_enable: assert property (timer_irq |-> ctrl1_ff[7:5] != 3'b000)
        else $error("interrupt without any enable");
    a_oe_follow_write: assert property (reg_wr && reg_addr == `REG_CTRL2 |=>
        compare_output_enable_ch1 == $past(reg_wdata[7])
        && compare_output_enable_ch2 == $past(reg_wdata[6]))
        else $error("output enables do not follow control two");
    a_force_pin_one: assert property (ctrl1_ff[`C1_FORCE1] && compare_output_enable_ch1
        ##0 s_plain_mode |=> compare_pin_ch1 == $past(ctrl1_ff[`C1_LEVEL1]))
        else $error("forced level one not on pin");
    a_force_pin_two: assert property (ctrl1_ff[`C1_FORCE2] && compare_output_enable_ch2
        ##0 s_plain_mode |=> compare_pin_ch2 == $past(ctrl1_ff[`C1_LEVEL2]))
        else $error("forced level two not on pin");
    a_unmapped_reads_zero: assert property (reg_rd && reg_addr > `REG_CNT_LO |=>
        reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // timer16_cc_monitor
bind timer16_capture_compare timer16_cc_monitor mon (.clk(clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_irq_mask(cpu_irq_mask),
    .capture_pin_ch1(capture_pin_ch1), .capture_pin_ch2(capture_pin_ch2),
    .compare_pin_ch1(compare_pin_ch1), .compare_pin_ch2(compare_pin_ch2),
    .compare_output_enable_ch1(compare_output_enable_ch1),
    .compare_output_enable_ch2(compare_output_enable_ch2), .timer_irq(timer_irq));
`default_nettype wire

// file: timer16_capture_compare_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cc_defs.vh"
module timer16_capture_compare_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic cpu_irq_mask = 1'b1;
    logic want_ch1 = 1'b0;
    logic want_ch2 = 1'b1;
    wire logic [7:0] reg_rdata;
    wire logic capture_pin_ch1;
    wire logic capture_pin_ch2;
    wire logic compare_pin_ch1;
    wire logic compare_pin_ch2;
    wire logic timer_irq;
    wire logic oe_ch1;
    wire logic oe_ch2;
    integer seed = 32'h6c3b;
    integer miscompares = 0;
    integer total_checks = 0;
    integer cyc_n = 0;
    integer n0;
    logic [7:0] rv;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [15:0] cap_a;
    timer16_capture_compare dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cpu_irq_mask(cpu_irq_mask),
        .capture_pin_ch1(capture_pin_ch1), .capture_pin_ch2(capture_pin_ch2),
        .compare_pin_ch1(compare_pin_ch1), .compare_pin_ch2(compare_pin_ch2),
        .compare_output_enable_ch1(oe_ch1), .compare_output_enable_ch2(oe_ch2),
        .timer_irq(timer_irq));
    capture_pin_driver src (.clk(clk), .want_ch1(want_ch1), .want_ch2(want_ch2),
        .capture_pin_ch1(capture_pin_ch1), .capture_pin_ch2(capture_pin_ch2));
    // Clock and a cycle count that stamps the capture requests.
    always #12.5 clk = ~clk;
    always @(posedge clk) cyc_n <= cyc_n + 1;
    ////////////////////////////////////////////////////////////////////////////
    // Comparison, bus cycles and the closing verdict.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
    begin
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    end
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
    begin
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clk);
    end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
    begin
        rd(a, v);
        chk(16'(v), 16'(e));
    end
    endtask
    task automatic wrap_up;
    begin
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence of scenarios.
    initial
    begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rdc(`REG_CTRL1, 8'h00);
        rdc(4'hE, 8'h00);
        repeat (8)
        begin
            rv = $random(seed);
            wr(`REG_CTRL1, rv);
            rdc(`REG_CTRL1, rv);
        end
        wr(`REG_CTRL1, 8'h82);
        want_ch1 <= 1'b1;
        n0 = cyc_n;
        repeat (6) @(posedge clk);
        rdc(`REG_STATUS, 8'h80);
        chk(16'(timer_irq), 16'h0000);
        cpu_irq_mask <= 1'b0;
        @(posedge clk);
        chk(16'(timer_irq), 16'h0001);
        rd(`REG_CAP1_HI, hi);
        rd(`REG_CAP1_LO, lo);
        cap_a = {hi, lo};
        rdc(`REG_STATUS, 8'h00);
        want_ch1 <= 1'b0;
        repeat (6) @(posedge clk);
        rdc(`REG_STATUS, 8'h00);
        want_ch1 <= 1'b1;
        n0 = cyc_n - n0;
        repeat (6) @(posedge clk);
        wr(`REG_CAP1_HI, 8'h5A);
        rd(`REG_STATUS, rv);
        rd(`REG_CAP1_HI, hi);
        rd(`REG_CAP1_LO, lo);
        chk({hi, lo} - cap_a, 16'(n0));
        want_ch1 <= 1'b0;
        repeat (4) @(posedge clk);
        rd(`REG_CAP1_HI, hi);
        want_ch1 <= 1'b1;
        repeat (6) @(posedge clk);
        rdc(`REG_STATUS, 8'h00);
        rdc(`REG_CAP1_LO, lo);
        wr(`REG_CTRL2, 8'h20);
        chk(16'({oe_ch1, oe_ch2}), 16'h0000);
        want_ch1 <= 1'b0;
        repeat (4) @(posedge clk);
        want_ch1 <= 1'b1;
        want_ch2 <= 1'b0;
        repeat (6) @(posedge clk);
        rdc(`REG_STATUS, 8'h10);
        chk(16'(timer_irq), 16'h0001);
        rd(`REG_CAP2_LO, rv);
        chk(16'(timer_irq), 16'h0000);
        wr(`REG_CTRL2, 8'hC0);
        chk(16'({oe_ch1, oe_ch2}), 16'h0003);
        wr(`REG_CTRL1, 8'h01);
        rd(`REG_CNT_LO, lo);
        rd(`REG_CNT_HI, hi);
        cap_a = {hi, lo} + 16'd300;
        wr(`REG_CMP1_HI, cap_a[15:8]);
        wr(`REG_CMP1_LO, cap_a[7:0]);
        rv = 8'h00;
        for (int i = 0; i < 400 && !rv[`STAT_CMPF1]; i++)
            rd(`REG_STATUS, rv);
        chk(16'(rv[`STAT_CMPF1]), 16'h0001);
        chk(16'(compare_pin_ch1), 16'h0001);
        chk(16'(timer_irq), 16'h0000);
        wr(`REG_CMP1_LO, cap_a[7:0]);
        rv = $random(seed);
        wr(`REG_CTRL1, {5'b01011, rv[1], 1'b0, rv[0]});
        repeat (2) @(posedge clk);
        chk(16'(compare_pin_ch1), 16'(rv[0]));
        chk(16'(compare_pin_ch2), 16'(rv[1]));
        chk(16'(timer_irq), 16'h0000);
        rdc(`REG_STATUS, 8'h00);
        wr(`REG_CTRL2, 8'hE0);
        wr(`REG_CTRL1, {5'b01011, ~rv[1], 1'b0, ~rv[0]});
        repeat (2) @(posedge clk);
        chk(16'(compare_pin_ch1), 16'(rv[0]));
        chk(16'(compare_pin_ch2), 16'(rv[1]));
        // A low clock enable must freeze the counter between two live reads.
        rd(`REG_CNT_LO, lo);
        clk_en <= 1'b0;
        repeat (5) @(posedge clk);
        clk_en <= 1'b1;
        rd(`REG_CNT_LO, hi);
        rv = hi - lo;
        chk(16'(rv), 16'h0002);
        // Run the counter through its wrap; compare two matches at the top value.
        wr(`REG_CTRL1, 8'h20);
        rv = 8'h00;
        for (int i = 0; i < 34000 && !rv[`STAT_OVF]; i++)
            rd(`REG_STATUS, rv);
        chk(16'(rv), 16'h0028);
        chk(16'(timer_irq), 16'h0001);
        rd(`REG_CNT_LO, lo);
        rdc(`REG_STATUS, 8'h08);
        chk(16'(timer_irq), 16'h0000);
        // A reset in mid-run brings control one and the pins back to zero.
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk(16'(compare_pin_ch1), 16'h0000);
        rdc(`REG_CTRL1, 8'h00);
        wrap_up();
    end
    // Cuts a hang short well after the scenarios should have ended.
    initial
    begin
        repeat (80000) @(posedge clk);
        miscompares = miscompares + 1;
        wrap_up();
    end
endmodule // timer16_capture_compare_bench
`default_nettype wire
